//--- verif/pafc_board.sv
// Purpose: board model behind the port pins
// Assumes: every pin has a fixed pull level when undriven
// Notes: a driven pin shows the block's own drive value

`timescale 1ns/1ps

module pafc_board
#(
   parameter int NPORT = 4
)
(
   // drive from the block
   input wire logic [NPORT-1:0][7:0] pin_out_i,
   input wire logic [NPORT-1:0][7:0] pin_oe_i,
   // pull levels of undriven pins
   input wire logic [NPORT-1:0][7:0] level_i,
   // levels seen by the block
   output logic [NPORT-1:0][7:0] pin_in_o
);
   // released pins fall to the pull level, not the last drive
   assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & level_i);
endmodule

//--- verif/pafc_properties.sv
// Purpose: port-level properties of the pin configuration block
// Assumes: bound to pafc_top, one clock domain
// Notes: derived pin outputs lag their register by one clock

`timescale 1ns/1ps

module pafc_chk
   import pafc_pkg::*;
#(
   parameter int NPORT = 4,
   parameter int CONV_PORT = 2,
   parameter int OSC_PORT = 3
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // avalon slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // pins
   input wire logic [NPORT-1:0][7:0] pin_out_o,
   input wire logic [NPORT-1:0][7:0] pin_oe_o,
   input wire logic [7:0] conv_analog_o,
   input wire logic [7:0] conv_sample_o,
   input wire logic osc_main_osc_o,
   input wire logic osc_main_ext_o,
   input wire logic osc_sub_osc_o,
   input wire logic osc_sub_ext_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // request seen and write accepted
   logic req;
   logic wacc;
   assign req = avs_read_i | avs_write_i;
   assign wacc = avs_write_i & ~avs_waitrequest_o;

   // ********
   // bus timing
   // ********
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   idle_rdata_a: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
      else $error("read data not zero outside answer");
   plain_lat_a: assert property (req && !$past(req) && avs_address_i != PAFC_OFS_BITOP
      |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
      else $error("plain access answer off");
   bitop_lat_a: assert property (avs_write_i && !$past(req) && avs_address_i == PAFC_OFS_BITOP
      |-> avs_waitrequest_o [*4] ##1 !avs_waitrequest_o)
      else $error("single-bit write answer off");

   // ********
   // pin state
   // ********
   rst_state_a: assert property (disable iff (1'b0) rst_i |=> avs_waitrequest_o && pin_out_o == '0
      && pin_oe_o == '0 && !osc_main_osc_o && !osc_main_ext_o && !osc_sub_osc_o && !osc_sub_ext_o)
      else $error("state not cleared by reset");
   // latch only moves after an accepted write, never on its own
   latch_hold_a: assert property ($changed({pin_out_o, pin_oe_o})
      |-> $past(wacc) || $past(wacc, 2) || $past(rst_i))
      else $error("pin drive changed without a write");
   conv_sample_a: assert property ($onehot0(conv_sample_o) && (conv_sample_o & ~conv_analog_o) == 8'h00)
      else $error("sampled converter pin not a single analog pin");
   conv_drive_a: assert property ((pin_oe_o[CONV_PORT] & conv_analog_o) == 8'h00)
      else $error("analog converter pin driven");
   osc_main_a: assert property (osc_main_osc_o |-> !osc_main_ext_o
      && pin_oe_o[OSC_PORT][2:1] == 2'h0 && pin_out_o[OSC_PORT][2:1] == 2'h0)
      else $error("main oscillator pins still driven");
   osc_sub_a: assert property (osc_sub_osc_o |-> !osc_sub_ext_o
      && pin_oe_o[OSC_PORT][4:3] == 2'h0 && pin_out_o[OSC_PORT][4:3] == 2'h0)
      else $error("sub oscillator pins still driven");
endmodule

bind pafc_top pafc_chk #(.NPORT(NPORT), .CONV_PORT(CONV_PORT), .OSC_PORT(OSC_PORT)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .conv_analog_o(conv_analog_o),
   .conv_sample_o(conv_sample_o), .osc_main_osc_o(osc_main_osc_o), .osc_main_ext_o(osc_main_ext_o),
   .osc_sub_osc_o(osc_sub_osc_o), .osc_sub_ext_o(osc_sub_ext_o)
);

//--- verif/testbench.sv
// Purpose: register-level test of the port configuration block
// Assumes: plain accesses answer in three edges, single-bit write in five
// Notes: bench waits one extra edge after each access for pin outputs

`timescale 1ns/1ps

module testbench
   import pafc_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic wrq;
   logic [3:0][7:0] pin_in, pin_out, pin_oe;
   logic [3:0][7:0] lvl = 32'h0000_FF3C;
   logic [7:0] conv_an, conv_smp;
   logic [3:0] osc;
   logic [7:0] osc_code [5] = '{8'h40, 8'hC0, 8'h10, 8'h30, 8'h00};
   logic [7:0] osc_oe [5] = '{8'hF9, 8'hFB, 8'hE7, 8'hEF, 8'hFF};
   logic [3:0] osc_flag [5] = '{4'h4, 4'h8, 4'h1, 4'h2, 4'h0};
   int n_mismatch = 0;
   int n_compared = 0;

   // design and board
   pafc_top dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
      .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .conv_analog_o(conv_an),
      .conv_sample_o(conv_smp), .osc_main_osc_o(osc[2]), .osc_main_ext_o(osc[3]),
      .osc_sub_osc_o(osc[0]), .osc_sub_ext_o(osc[1])
   );
   pafc_board #(.NPORT(4)) board_u (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .level_i(lvl), .pin_in_o(pin_in));

   // 50 MHz clock
   initial
   begin
      forever #10 clk_i = ~clk_i;
   end

   // ********
   // tasks
   // ********
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   // one access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wrq !== 1'b0 && n < 40);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wrq !== 1'b0)
      begin
         n_mismatch++;
         test_done();
      end
      @(posedge clk_i);
      #1;
   endtask

   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // ********
   // main sequence
   // ********
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset state of every port
      for (int p = 0; p < 4; p++)
      begin
         rchk(PAFC_OFS_DATA + 6'(4 * p), {24'h0, lvl[p]});
         rchk(PAFC_OFS_DIR + 6'(4 * p), 32'hFF);
      end
      rchk(PAFC_OFS_CLKPIN, 32'h0);
      chk({28'h0, osc}, 32'h0);
      chk(pin_oe, 32'h0);
      chk(pin_out, 32'h0);
      // mixed port: low nibble outputs
      bus(1'b1, PAFC_OFS_DIR, 32'hF0);
      bus(1'b1, PAFC_OFS_DATA, 32'hA5);
      chk({24'h0, pin_out[0]}, 32'hA5);
      chk({24'h0, pin_oe[0]}, 32'h0F);
      rchk(PAFC_OFS_DATA, 32'h35);
      // single-bit writes pick up input levels
      bus(1'b1, PAFC_OFS_DIR + 6'h04, 32'hFE);
      bus(1'b1, PAFC_OFS_BITOP, 32'h101);
      rchk(PAFC_OFS_BITOP, 32'h101);
      chk({24'h0, pin_out[1]}, 32'hFF);
      bus(1'b1, PAFC_OFS_BITOP, 32'h100);
      chk({24'h0, pin_out[1]}, 32'hFE);
      bus(1'b1, PAFC_OFS_DATA + 6'h04, 32'h00);
      bus(1'b1, PAFC_OFS_DIR + 6'h04, 32'h00);
      bus(1'b1, PAFC_OFS_BITOP, 32'h171);
      chk({pin_oe[1], pin_out[1]}, 32'hFF80);
      // analog select table, then a refused value
      for (int k = 0; k <= 8; k++)
      begin
         bus(1'b1, PAFC_OFS_ADSEL, 32'(k));
         chk({24'h0, conv_an}, {24'h0, 8'hFF << k});
      end
      bus(1'b1, PAFC_OFS_ADSEL, 32'h9);
      rchk(PAFC_OFS_ADSEL, 32'h8);
      bus(1'b1, PAFC_OFS_ADSEL, 32'h0);
      bus(1'b1, PAFC_OFS_CHSEL, 32'h5);
      chk({24'h0, conv_smp}, 32'h20);
      bus(1'b1, PAFC_OFS_DIR + 6'h08, 32'hFE);
      chk({pin_oe[2], conv_smp}, 32'h0020);
      rchk(PAFC_OFS_STAT, 32'h01FF);
      bus(1'b1, PAFC_OFS_ADSEL, 32'h4);
      chk({pin_oe[2], conv_an}, 32'h01F0);
      rchk(PAFC_OFS_STAT, 32'h00F0);
      bus(1'b1, PAFC_OFS_CHSEL, 32'h2);
      chk({24'h0, conv_smp}, 32'h0);
      // oscillator pin modes over a driven port
      bus(1'b1, PAFC_OFS_DIR + 6'h0C, 32'h00);
      bus(1'b1, PAFC_OFS_DATA + 6'h0C, 32'hFF);
      for (int k = 0; k < 5; k++)
      begin
         bus(1'b1, PAFC_OFS_CLKPIN, {24'h0, osc_code[k]});
         chk({pin_oe[3], pin_out[3]}, {osc_oe[k], osc_oe[k]});
         chk({28'h0, osc}, {28'h0, osc_flag[k]});
      end
      rchk(PAFC_OFS_DATA + 6'h0C, 32'hFF);
      rchk(6'h34, 32'h0);
      // second reset in mid-run
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(PAFC_OFS_CLKPIN, 32'h0);
      chk(pin_out, 32'h0);
      test_done();
   end
endmodule

//--- verilog/pafc_avl.sv
// Purpose: Avalon-MM slave front end with waitrequest
// Assumes: master holds the request until waitrequest is sampled low
// Notes: waitrequest is high by default and drops for exactly one cycle

`timescale 1ns/1ps

module pafc_avl
   import pafc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // avalon slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // register file side
   pafc_reg_if.bus rif
);

   typedef enum logic [1:0] {PAFC_B_IDLE, PAFC_B_BUSY, PAFC_B_ACK} pafc_bst_t;
   typedef struct packed {
      pafc_bst_t st;
      logic wait_r;
      logic [31:0] rdata;
   } pafc_avl_t;

   pafc_avl_t s_q;
   pafc_avl_t s_d;

   // ****************************************************************
   // handshake
   // ****************************************************************
   // request fields pass straight through; the master keeps them steady
   assign rif.start = (s_q.st == PAFC_B_IDLE) && (avs_read_i || avs_write_i);
   assign rif.commit = (s_q.st == PAFC_B_ACK) && avs_write_i;
   assign rif.write = avs_write_i;
   assign rif.addr = avs_address_i;
   assign rif.wdata = avs_writedata_i;
   assign rif.be = avs_byteenable_i;

   // next state
   always_comb
   begin
      s_d = s_q;
      unique case (s_q.st)
         PAFC_B_IDLE:
         begin
            if (avs_read_i || avs_write_i)
            begin
               s_d.st = PAFC_B_BUSY;
            end
         end
         PAFC_B_BUSY:
         begin
            if (rif.done)
            begin
               s_d.st = PAFC_B_ACK;
               s_d.wait_r = 1'b0;
               s_d.rdata = avs_read_i ? rif.rdata : 32'h00000000;
            end
         end
         PAFC_B_ACK:
         begin
            // read data drop back to zero once the answer cycle is over
            s_d.st = PAFC_B_IDLE;
            s_d.wait_r = 1'b1;
            s_d.rdata = 32'h00000000;
         end
         default:
         begin
            s_d.st = PAFC_B_IDLE;
            s_d.wait_r = 1'b1;
            s_d.rdata = 32'h00000000;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '{st: PAFC_B_IDLE, wait_r: 1'b1, rdata: 32'h00000000};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign avs_readdata_o = s_q.rdata;
   assign avs_waitrequest_o = s_q.wait_r;

endmodule

//--- verilog/pafc_conv.sv
// Purpose: converter pin function decode
// Assumes: select value already limited to the legal range
// Notes: purely combinational, registered by the caller

`timescale 1ns/1ps

module pafc_conv
   import pafc_pkg::*;
(
   // configuration
   input wire logic [3:0] adsel_i,
   input wire logic [7:0] dir_i,
   input wire logic [2:0] chsel_i,
   // decoded pin function
   output logic [7:0] analog_o,
   output logic [7:0] sample_o,
   output logic [7:0] bad_o
);

   logic [7:0] chan_hot;

   // channel select as one-hot
   always_comb
   begin
      chan_hot = 8'h00;
      chan_hot[chsel_i] = 1'b1;
   end

   // function follows select plus direction bits
   assign analog_o = pafc_analog_mask(adsel_i);
   assign sample_o = analog_o & dir_i & chan_hot;
   assign bad_o = analog_o & ~dir_i;

endmodule

//--- verilog/pafc_pkg.sv
// Purpose: shared constants, register map and helpers of the port configuration block
// Assumes: 32-bit Avalon-MM word registers, 8-bit ports
// Notes: offsets are byte addresses; each register takes one aligned word

package pafc_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [5:0] PAFC_OFS_DATA = 6'h00; // port_data_register, +4 per port
   localparam logic [5:0] PAFC_OFS_DIR = 6'h10; // port_direction_field, +4 per port
   localparam logic [5:0] PAFC_OFS_ADSEL = 6'h20; // analog_digital_select
   localparam logic [5:0] PAFC_OFS_CHSEL = 6'h24; // conversion_channel_select
   localparam logic [5:0] PAFC_OFS_CLKPIN = 6'h28; // clock_pin_mode_select
   localparam logic [5:0] PAFC_OFS_BITOP = 6'h2C; // single-bit write command
   localparam logic [5:0] PAFC_OFS_STAT = 6'h30; // converter pin status

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] PAFC_RST_DATA = 8'h00;
   localparam logic [7:0] PAFC_RST_DIR = 8'hFF;
   localparam logic [3:0] PAFC_RST_ADSEL = 4'h0;
   localparam logic [2:0] PAFC_RST_CHSEL = 3'h0;
   localparam logic [7:0] PAFC_RST_CLKPIN = 8'h00;
   localparam logic [9:0] PAFC_RST_BITOP = 10'h000;

   // ****************************************************************
   // field positions and limits
   // ****************************************************************
   localparam int PAFC_CLK_MAIN_EXT = 7;
   localparam int PAFC_CLK_MAIN_OSC = 6;
   localparam int PAFC_CLK_SUB_EXT = 5;
   localparam int PAFC_CLK_SUB_OSC = 4;
   localparam int PAFC_BIT_VAL = 0;
   localparam int PAFC_BIT_POS_LSB = 4;
   localparam int PAFC_BIT_PORT_LSB = 8;
   localparam int PAFC_STAT_BAD_LSB = 8;
   localparam logic [3:0] PAFC_ADSEL_MAX = 4'h8;
   localparam int PAFC_OSC_MAIN_A = 1; // resonator side of main pair
   localparam int PAFC_OSC_MAIN_B = 2; // resonator or external clock input
   localparam int PAFC_OSC_SUB_A = 3;
   localparam int PAFC_OSC_SUB_B = 4;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // read view of a port: pin level in input mode, latch in output mode
   function automatic logic [7:0] pafc_port_read(input logic [7:0] latch, input logic [7:0] dir,
                                                 input logic [7:0] pin);
      pafc_port_read = (dir & pin) | (~dir & latch);
   endfunction

   // pins below the select value are digital, the rest analog
   function automatic logic [7:0] pafc_analog_mask(input logic [3:0] adsel);
      logic [8:0] dig;
      dig = 9'h000;
      for (int i = 0; i < 8; i++)
      begin
         dig[i] = (4'(i) < adsel);
      end
      pafc_analog_mask = ~dig[7:0];
   endfunction

endpackage

//--- verilog/pafc_reg_if.sv
// Purpose: register access channel between bus slave and register file
// Assumes: one access in flight at a time
// Notes: start and commit are one-cycle pulses

`timescale 1ns/1ps

interface pafc_reg_if;
   logic start; // access accepted
   logic commit; // write takes effect now
   logic write;
   logic [5:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic done; // register file ready to answer
   logic [31:0] rdata;

   modport bus (output start, commit, write, addr, wdata, be, input done, rdata);
   modport regs (input start, commit, write, addr, wdata, be, output done, rdata);
endinterface

//--- verilog/pafc_top.sv
// Purpose: port pin configuration for alternate-function use, with single-bit write
// Assumes: pin inputs synchronous to clk_i; register access over Avalon-MM
// Notes: one port carries converter inputs, one carries the four oscillator pins
//
// How it works
// - analog, input-mode, selected converter pin becomes the sampled input.
// - analog, input-mode, unselected converter pin stays analog, not converted.
// - converter pin follows analog select and direction; analog plus output prohibited.
// - oscillator pins in clock modes ignore direction and latch bits.
// - clock pin mode select resets to zero, all pins ordinary port pins.
// - single-bit write is read eight bits, modify one, write eight back.
// - writes update latches; reads give latch for outputs, pin for inputs.
// - single-bit write also loads untargeted input latches with pin levels.
// - direction zero enables output buffer, one makes pin an input.
// - reset clears latches; a written latch holds until rewritten.

`timescale 1ns/1ps

module pafc_top
   import pafc_pkg::*;
#(
   parameter int NPORT = 4,
   parameter int CONV_PORT = 2,
   parameter int OSC_PORT = 3
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // avalon slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // board pins
   input wire logic [NPORT-1:0][7:0] pin_in_i,
   output logic [NPORT-1:0][7:0] pin_out_o,
   output logic [NPORT-1:0][7:0] pin_oe_o,
   // converter pins
   output logic [7:0] conv_analog_o,
   output logic [7:0] conv_sample_o,
   // oscillator pin modes
   output logic osc_main_osc_o,
   output logic osc_main_ext_o,
   output logic osc_sub_osc_o,
   output logic osc_sub_ext_o
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // the map has room for four ports at two address bits
   if (NPORT < 1 || NPORT > 4)
   begin : g_chk_nport
      $error("pafc_top: NPORT must be 1 to 4");
   end
   if (CONV_PORT >= NPORT || OSC_PORT >= NPORT || CONV_PORT == OSC_PORT)
   begin : g_chk_ports
      $error("pafc_top: converter and oscillator ports must be distinct and present");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [1:0] {PAFC_T_IDLE, PAFC_T_RD, PAFC_T_MOD, PAFC_T_DONE} pafc_tst_t;
   typedef struct packed {
      logic [NPORT-1:0][7:0] data;
      logic [NPORT-1:0][7:0] dir;
      logic [3:0] adsel;
      logic [2:0] chsel;
      logic [7:0] clkpin;
      logic [9:0] bitcmd;
      pafc_tst_t tst;
      logic [7:0] rmw;
      logic [NPORT-1:0][7:0] pin_out;
      logic [NPORT-1:0][7:0] pin_oe;
      logic [7:0] analog;
      logic [7:0] sample;
      logic [7:0] bad;
      logic [3:0] osc;
   } pafc_top_t;

   pafc_top_t s_q;
   pafc_top_t s_d;

   pafc_reg_if rif();

   logic [7:0] conv_analog;
   logic [7:0] conv_sample;
   logic [7:0] conv_bad;
   logic [1:0] acc_port;
   logic [1:0] bit_port;
   logic [2:0] bit_pos;
   logic bitop_wr;
   logic [7:0] osc_taken;
   logic [7:0] be0_data;

   // ****************************************************************
   // bus front end and converter decode
   // ****************************************************************
   pafc_avl u_avl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .rif(rif.bus)
   );

   pafc_conv u_conv (
      .adsel_i(s_q.adsel),
      .dir_i(s_q.dir[CONV_PORT]),
      .chsel_i(s_q.chsel),
      .analog_o(conv_analog),
      .sample_o(conv_sample),
      .bad_o(conv_bad)
   );

   // ****************************************************************
   // access decode
   // ****************************************************************
   assign acc_port = rif.addr[3:2];
   assign bit_port = s_q.bitcmd[PAFC_BIT_PORT_LSB +: 2];
   assign bit_pos = s_q.bitcmd[PAFC_BIT_POS_LSB +: 3];
   assign bitop_wr = rif.write && (rif.addr == PAFC_OFS_BITOP);
   assign be0_data = rif.wdata[7:0];

   // plain accesses answer at once; single-bit writes wait for the sequence
   assign rif.done = (s_q.tst == PAFC_T_DONE) || (s_q.tst == PAFC_T_IDLE && !bitop_wr);

   // oscillator pins claimed by the clock pin mode select
   always_comb
   begin
      osc_taken = 8'h00;
      osc_taken[PAFC_OSC_MAIN_A] = s_q.clkpin[PAFC_CLK_MAIN_OSC] && !s_q.clkpin[PAFC_CLK_MAIN_EXT];
      osc_taken[PAFC_OSC_MAIN_B] = s_q.clkpin[PAFC_CLK_MAIN_OSC];
      osc_taken[PAFC_OSC_SUB_A] = s_q.clkpin[PAFC_CLK_SUB_OSC] && !s_q.clkpin[PAFC_CLK_SUB_EXT];
      osc_taken[PAFC_OSC_SUB_B] = s_q.clkpin[PAFC_CLK_SUB_OSC];
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   // unmapped addresses and absent ports read as zero
   always_comb
   begin
      rif.rdata = 32'h00000000;
      if (rif.addr[5:4] == PAFC_OFS_DATA[5:4] && rif.addr[1:0] == 2'b00)
      begin
         if (int'(acc_port) < NPORT)
         begin
            rif.rdata[7:0] = pafc_port_read(s_q.data[acc_port], s_q.dir[acc_port],
                                            pin_in_i[acc_port]);
         end
      end
      else if (rif.addr[5:4] == PAFC_OFS_DIR[5:4] && rif.addr[1:0] == 2'b00)
      begin
         if (int'(acc_port) < NPORT)
         begin
            rif.rdata[7:0] = s_q.dir[acc_port];
         end
      end
      else
      begin
         unique case (rif.addr)
            PAFC_OFS_ADSEL: rif.rdata[3:0] = s_q.adsel;
            PAFC_OFS_CHSEL: rif.rdata[2:0] = s_q.chsel;
            PAFC_OFS_CLKPIN: rif.rdata[7:0] = s_q.clkpin;
            PAFC_OFS_BITOP: rif.rdata[9:0] = s_q.bitcmd;
            PAFC_OFS_STAT: rif.rdata[15:0] = {s_q.bad, s_q.analog};
            default: rif.rdata = 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      s_d = s_q;

      // single-bit write sequence: read, modify, then write at commit
      unique case (s_q.tst)
         PAFC_T_IDLE:
         begin
            if (rif.start && bitop_wr)
            begin
               s_d.bitcmd = rif.wdata[9:0];
               s_d.tst = PAFC_T_RD;
            end
         end
         PAFC_T_RD:
         begin
            // whole port is read, input pins give their live level
            if (int'(bit_port) < NPORT)
            begin
               s_d.rmw = pafc_port_read(s_q.data[bit_port], s_q.dir[bit_port],
                                        pin_in_i[bit_port]);
            end
            s_d.tst = PAFC_T_MOD;
         end
         PAFC_T_MOD:
         begin
            s_d.rmw[bit_pos] = s_q.bitcmd[PAFC_BIT_VAL];
            s_d.tst = PAFC_T_DONE;
         end
         PAFC_T_DONE:
         begin
            if (rif.commit)
            begin
               s_d.tst = PAFC_T_IDLE;
               if (int'(bit_port) < NPORT)
               begin
                  s_d.data[bit_port] = s_q.rmw;
               end
            end
         end
      endcase

      // plain register writes, low byte lane only carries data
      if (rif.commit && rif.be[0] && !bitop_wr)
      begin
         if (rif.addr[5:4] == PAFC_OFS_DATA[5:4] && rif.addr[1:0] == 2'b00)
         begin
            if (int'(acc_port) < NPORT)
            begin
               s_d.data[acc_port] = be0_data;
            end
         end
         else if (rif.addr[5:4] == PAFC_OFS_DIR[5:4] && rif.addr[1:0] == 2'b00)
         begin
            if (int'(acc_port) < NPORT)
            begin
               s_d.dir[acc_port] = be0_data;
            end
         end
         else if (rif.addr == PAFC_OFS_ADSEL)
         begin
            // prohibited select values are refused, the old value stays
            if (be0_data[3:0] <= PAFC_ADSEL_MAX && be0_data[7:4] == 4'h0)
            begin
               s_d.adsel = be0_data[3:0];
            end
         end
         else if (rif.addr == PAFC_OFS_CHSEL)
         begin
            s_d.chsel = be0_data[2:0];
         end
         else if (rif.addr == PAFC_OFS_CLKPIN)
         begin
            s_d.clkpin = be0_data;
         end
      end

      // pin drive: direction zero drives, converter analog and clock pins never do
      for (int p = 0; p < NPORT; p++)
      begin
         s_d.pin_out[p] = s_q.data[p];
         s_d.pin_oe[p] = ~s_q.dir[p];
         if (p == CONV_PORT)
         begin
            s_d.pin_oe[p] = ~s_q.dir[p] & ~conv_analog;
         end
         if (p == OSC_PORT)
         begin
            s_d.pin_oe[p] = ~s_q.dir[p] & ~osc_taken;
            s_d.pin_out[p] = s_q.data[p] & ~osc_taken;
         end
      end

      // converter and oscillator status, registered for the ports
      s_d.analog = conv_analog;
      s_d.sample = conv_sample;
      s_d.bad = conv_bad;
      s_d.osc[0] = s_q.clkpin[PAFC_CLK_MAIN_OSC] && !s_q.clkpin[PAFC_CLK_MAIN_EXT];
      s_d.osc[1] = s_q.clkpin[PAFC_CLK_MAIN_OSC] && s_q.clkpin[PAFC_CLK_MAIN_EXT];
      s_d.osc[2] = s_q.clkpin[PAFC_CLK_SUB_OSC] && !s_q.clkpin[PAFC_CLK_SUB_EXT];
      s_d.osc[3] = s_q.clkpin[PAFC_CLK_SUB_OSC] && s_q.clkpin[PAFC_CLK_SUB_EXT];
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // reset values match the decoded outputs except analog and sample, which reset to zero, not FF and 01
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q.data <= {NPORT{PAFC_RST_DATA}};
         s_q.dir <= {NPORT{PAFC_RST_DIR}};
         s_q.adsel <= PAFC_RST_ADSEL;
         s_q.chsel <= PAFC_RST_CHSEL;
         s_q.clkpin <= PAFC_RST_CLKPIN;
         s_q.bitcmd <= PAFC_RST_BITOP;
         s_q.tst <= PAFC_T_IDLE;
         s_q.rmw <= 8'h00;
         s_q.pin_out <= {NPORT{8'h00}};
         s_q.pin_oe <= {NPORT{8'h00}};
         s_q.analog <= 8'h00;
         s_q.sample <= 8'h00;
         s_q.bad <= 8'h00;
         s_q.osc <= 4'h0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign pin_out_o = s_q.pin_out;
   assign pin_oe_o = s_q.pin_oe;
   assign conv_analog_o = s_q.analog;
   assign conv_sample_o = s_q.sample;
   assign osc_main_osc_o = s_q.osc[0];
   assign osc_main_ext_o = s_q.osc[1];
   assign osc_sub_osc_o = s_q.osc[2];
   assign osc_sub_ext_o = s_q.osc[3];

endmodule
